// ==== design/ssfl_core.sv ====
// serial port status and interrupt flag logic with a byte engine
// assumes APB master on the core clock; serial pins are asynchronous
// ----------------------------------------------------------------
// Overview of operation
// - as checking master, slave select pulled low while the engine is busy sets the multimaster error
// - multimaster error holds until software writes zero to it
// - receive overflow is status bit 5, cleared by reading receive buffer
// - with overflow clear, the receive buffer holds valid data
// - mode one: unread buffer at end of next byte sets overflow
// - overflow with overwrite set replaces buffer with new byte
// - overflow with overwrite clear drops new byte, keeps old data
// - receive interrupt bit 4 sets on new byte, clears on buffer read
// - mode zero: raise interrupt; unread receive buffer stops master transfer
// - receive full bit 3 sets on full buffer, clears on buffer read
// - underflow bit 2 sets when transmit buffer empties; write zero clears
// - transmit interrupt bit 1 clears when software writes transmit buffer
// - mode zero: transmit interrupt zero means buffer full, one means empty
// - mode one: set flag on empty, interrupt; unrefilled buffer stops master transfer
// - transmit full bit 0 set while buffer full; write zero clears
module ssfl_core (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ssfl_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ssfl_pkg::BUS_W-1:0] pwdata,
   output logic [ssfl_pkg::BUS_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe_n,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_n,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_n,
   input wire logic ss_n_in,
   output logic ss_n_out,
   output logic ss_oe_n
);

   localparam int DW = ssfl_pkg::DATA_W;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [ssfl_pkg::PIN_W-1:0] pin_sync;
   logic sclk_s;
   logic mosi_s;
   logic miso_s;
   logic ss_n_s;

   ssfl_sync #(
      .WIDTH(ssfl_pkg::PIN_W),
      .RESET_VAL(ssfl_pkg::PIN_IDLE)
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .din({ss_n_in, miso_in, mosi_in, sclk_in}),
      .dout(pin_sync)
   );

   assign sclk_s = pin_sync[0];
   assign mosi_s = pin_sync[1];
   assign miso_s = pin_sync[2];
   assign ss_n_s = pin_sync[3];

   // ----------------------------------------------------------------
   // state declarations
   // ----------------------------------------------------------------
   logic [DW-1:0] cfg_ff;
   logic [DW-1:0] tx_buf_ff;
   logic [DW-1:0] rx_buf_ff;
   logic [DW-1:0] tx_shift_ff;
   logic [DW-1:0] rx_shift_ff;
   logic tx_full_ff;
   logic rx_full_ff;
   logic rxirq_ff;
   logic rxof_ff;
   logic txirq_ff;
   logic txuf_ff;
   logic txbf_ff;
   logic multimaster_error_flag_ff;
   logic rx_block_ff;
   logic [ssfl_pkg::EV_W-1:0] evt_ff;
   logic [ssfl_pkg::EV_W-1:0] mask_ff;
   logic [ssfl_pkg::BIT_CNT_W-1:0] bit_cnt_ff;
   logic [7:0] div_cnt_ff;
   logic sclk_prev_ff;
   ssfl_pkg::ssfl_eng_e state_ff;
   logic [ssfl_pkg::BUS_W-1:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic irq_ff;
   logic sclk_out_ff;
   logic sclk_oe_n_ff;
   logic mosi_out_ff;
   logic mosi_oe_n_ff;
   logic miso_out_ff;
   logic miso_oe_n_ff;
   logic ss_n_out_ff;
   logic ss_oe_n_ff;

   initial
   begin
      if (ssfl_pkg::HALF_CYC > 255)
         $error("ssfl_core: half serial clock period exceeds divider width");
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic acc;
   logic done;
   logic wr_done;
   logic rd_done;
   logic mapped;
   logic tx_write;
   logic rx_read;
   logic stat_write;
   logic [DW-1:0] wbyte;

   assign acc = psel & penable & ~pready_ff;
   assign done = psel & penable & pready_ff;
   assign wr_done = done & pwrite;
   assign rd_done = done & ~pwrite;
   assign wbyte = pwdata[DW-1:0];
   assign mapped = (paddr == ssfl_pkg::ADDR_TX) | (paddr == ssfl_pkg::ADDR_RX)
      | (paddr == ssfl_pkg::ADDR_CFG) | (paddr == ssfl_pkg::ADDR_STAT)
      | (paddr == ssfl_pkg::ADDR_EVT) | (paddr == ssfl_pkg::ADDR_MASK);
   assign tx_write = wr_done & (paddr == ssfl_pkg::ADDR_TX);
   assign rx_read = rd_done & (paddr == ssfl_pkg::ADDR_RX);
   assign stat_write = wr_done & (paddr == ssfl_pkg::ADDR_STAT);

   // ----------------------------------------------------------------
   // engine events
   // ----------------------------------------------------------------
   logic master;
   logic mode1;
   logic lsb_first;
   logic half_tick;
   logic rise;
   logic fall;
   logic byte_done;
   logic boundary;
   logic in_bit;
   logic [DW-1:0] new_byte;
   logic multimaster_error_flag_set;
   logic start;
   logic go_on;
   logic tx_take;
   logic rx_land;
   logic ovf;
   logic stop_ev;

   assign master = cfg_ff[ssfl_pkg::CFG_MASTER];
   assign mode1 = cfg_ff[ssfl_pkg::CFG_MODE];
   assign lsb_first = cfg_ff[ssfl_pkg::CFG_LSB];
   assign half_tick = (div_cnt_ff == 8'(ssfl_pkg::HALF_CYC - 1));
   assign rise = (state_ff == ssfl_pkg::ST_SHIFT) & (master
      ? (half_tick & ~sclk_out_ff) : (sclk_s & ~sclk_prev_ff));
   assign fall = (state_ff == ssfl_pkg::ST_SHIFT) & (master
      ? (half_tick & sclk_out_ff) : (~sclk_s & sclk_prev_ff));
   assign byte_done = rise & (bit_cnt_ff == ssfl_pkg::BIT_LAST);
   assign boundary = fall & (bit_cnt_ff == '0);
   assign in_bit = master ? miso_s : mosi_s;
   assign new_byte = lsb_first ? {in_bit, rx_shift_ff[DW-1:1]}
      : {rx_shift_ff[DW-2:0], in_bit};
   assign multimaster_error_flag_set = master & cfg_ff[ssfl_pkg::CFG_SS_CHECK]
      & (state_ff != ssfl_pkg::ST_IDLE) & ~ss_n_s;
   assign start = (state_ff == ssfl_pkg::ST_IDLE)
      & (master ? tx_full_ff : ~ss_n_s);
   // master carries on only with a refilled buffer and, in mode zero, a serviced rx side
   assign go_on = tx_full_ff & ~(~mode1 & rx_block_ff);
   assign tx_take = tx_full_ff & (start | (boundary & (~master | go_on)));
   assign stop_ev = master & boundary & ~go_on & ~multimaster_error_flag_set;
   assign ovf = byte_done & rx_full_ff & ~rx_read;
   assign rx_land = byte_done & (~ovf | cfg_ff[ssfl_pkg::CFG_OVERWRITE]);

   // ----------------------------------------------------------------
   // engine state machine
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
         state_ff <= ssfl_pkg::ST_IDLE;
      else
      begin
         case (state_ff)
            ssfl_pkg::ST_IDLE:
               if (start)
                  state_ff <= master ? ssfl_pkg::ST_LEAD : ssfl_pkg::ST_SHIFT;
            ssfl_pkg::ST_LEAD:
               if (multimaster_error_flag_set)
                  state_ff <= ssfl_pkg::ST_IDLE;
               else if (half_tick)
                  state_ff <= ssfl_pkg::ST_SHIFT;
            ssfl_pkg::ST_SHIFT:
               if (multimaster_error_flag_set | (~master & ss_n_s))
                  state_ff <= ssfl_pkg::ST_IDLE;
               else if (stop_ev)
                  state_ff <= ssfl_pkg::ST_TAIL;
            ssfl_pkg::ST_TAIL:
               if (half_tick | multimaster_error_flag_set)
                  state_ff <= ssfl_pkg::ST_IDLE;
            default:
               state_ff <= ssfl_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // serial clock, divider and shifters
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         div_cnt_ff <= '0;
         sclk_prev_ff <= 1'b0;
         sclk_out_ff <= 1'b0;
         bit_cnt_ff <= '0;
         tx_shift_ff <= '0;
         rx_shift_ff <= '0;
         rx_block_ff <= 1'b0;
      end
      else
      begin
         sclk_prev_ff <= sclk_s;
         if (state_ff == ssfl_pkg::ST_IDLE | half_tick)
            div_cnt_ff <= '0;
         else
            div_cnt_ff <= div_cnt_ff + 8'h01;
         if (state_ff != ssfl_pkg::ST_SHIFT | multimaster_error_flag_set)
            sclk_out_ff <= 1'b0;
         else if (master & half_tick)
            sclk_out_ff <= ~sclk_out_ff;
         if (start)
            bit_cnt_ff <= '0;
         else if (rise)
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
         if (rise)
            rx_shift_ff <= new_byte;
         if (byte_done)
            rx_block_ff <= rx_full_ff & ~rx_read;
         if (tx_take)
            tx_shift_ff <= tx_buf_ff;
         else if (start | boundary)
            tx_shift_ff <= '0;
         else if (fall)
            tx_shift_ff <= lsb_first ? {1'b0, tx_shift_ff[DW-1:1]}
               : {tx_shift_ff[DW-2:0], 1'b0};
      end
   end

   // ----------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mosi_out_ff <= 1'b0;
         miso_out_ff <= 1'b0;
         sclk_oe_n_ff <= 1'b1;
         mosi_oe_n_ff <= 1'b1;
         miso_oe_n_ff <= 1'b1;
         ss_n_out_ff <= 1'b1;
         ss_oe_n_ff <= 1'b1;
      end
      else
      begin
         mosi_out_ff <= lsb_first ? tx_shift_ff[0] : tx_shift_ff[DW-1];
         miso_out_ff <= lsb_first ? tx_shift_ff[0] : tx_shift_ff[DW-1];
         sclk_oe_n_ff <= ~master;
         mosi_oe_n_ff <= ~master;
         miso_oe_n_ff <= master | ss_n_s;
         ss_oe_n_ff <= ~master | cfg_ff[ssfl_pkg::CFG_SS_CHECK];
         // select drops for the frame and rises when the frame ends
         ss_n_out_ff <= ~(master & (state_ff != ssfl_pkg::ST_IDLE)
            & ~(state_ff == ssfl_pkg::ST_TAIL & half_tick));
      end
   end

   // ----------------------------------------------------------------
   // buffers
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tx_buf_ff <= '0;
         rx_buf_ff <= '0;
         tx_full_ff <= 1'b0;
         rx_full_ff <= 1'b0;
      end
      else
      begin
         if (tx_write)
            tx_buf_ff <= wbyte;
         tx_full_ff <= tx_write | (tx_full_ff & ~tx_take);
         if (rx_land)
            rx_buf_ff <= new_byte;
         rx_full_ff <= rx_land | (rx_full_ff & ~rx_read);
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   logic nxt_tx_full;

   assign nxt_tx_full = tx_write | (tx_full_ff & ~tx_take);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rxirq_ff <= 1'b0;
         rxof_ff <= 1'b0;
         txirq_ff <= 1'b0;
         txuf_ff <= 1'b0;
         txbf_ff <= 1'b0;
         multimaster_error_flag_ff <= 1'b0;
      end
      else
      begin
         multimaster_error_flag_ff <= multimaster_error_flag_set
            | (multimaster_error_flag_ff & ~(stat_write & ~wbyte[ssfl_pkg::ST_MULTIMASTER_ERROR_FLAG]));
         rxof_ff <= (ovf & mode1) | (rxof_ff & ~rx_read);
         rxirq_ff <= rx_land | (rxirq_ff & ~rx_read);
         txuf_ff <= tx_take
            | (txuf_ff & ~(stat_write & ~wbyte[ssfl_pkg::ST_TXUF]));
         txbf_ff <= nxt_tx_full
            | (txbf_ff & ~(stat_write & ~wbyte[ssfl_pkg::ST_TXBF]));
         if (mode1)
            txirq_ff <= tx_take | (txirq_ff & ~tx_write
               & ~(stat_write & ~wbyte[ssfl_pkg::ST_TXIRQ]));
         else
            txirq_ff <= ~nxt_tx_full;
      end
   end

   // ----------------------------------------------------------------
   // interrupt events, mask and output
   // ----------------------------------------------------------------
   logic [ssfl_pkg::EV_W-1:0] ev_set;

   always_comb
   begin
      ev_set = '0;
      ev_set[ssfl_pkg::EV_RX] = rx_land & ~mode1;
      ev_set[ssfl_pkg::EV_TX] = tx_take & mode1;
      ev_set[ssfl_pkg::EV_OVF] = ovf & mode1;
      ev_set[ssfl_pkg::EV_MULTIMASTER_ERROR_FLAG] = multimaster_error_flag_set;
      ev_set[ssfl_pkg::EV_STOP] = stop_ev;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         evt_ff <= ssfl_pkg::EV_RESET;
         irq_ff <= 1'b0;
      end
      else
      begin
         if (wr_done & (paddr == ssfl_pkg::ADDR_EVT))
            evt_ff <= ev_set | (evt_ff & ~pwdata[ssfl_pkg::EV_W-1:0]);
         else
            evt_ff <= ev_set | evt_ff;
         irq_ff <= |(evt_ff & mask_ff);
      end
   end

   // ----------------------------------------------------------------
   // register writes and APB answer
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cfg_ff <= ssfl_pkg::CFG_RESET;
         mask_ff <= ssfl_pkg::EV_RESET;
      end
      else if (wr_done)
      begin
         if (paddr == ssfl_pkg::ADDR_CFG)
            cfg_ff <= wbyte;
         if (paddr == ssfl_pkg::ADDR_MASK)
            mask_ff <= pwdata[ssfl_pkg::EV_W-1:0];
      end
   end

   logic [DW-1:0] stat_byte;

   assign stat_byte = {state_ff != ssfl_pkg::ST_IDLE, multimaster_error_flag_ff, rxof_ff, rxirq_ff,
      rx_full_ff, txuf_ff, txirq_ff, txbf_ff};

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff <= acc;
         pslverr_ff <= acc & ~mapped;
         if (acc & ~pwrite)
         begin
            case (paddr)
               ssfl_pkg::ADDR_RX:
                  prdata_ff <= 32'(rx_buf_ff);
               ssfl_pkg::ADDR_CFG:
                  prdata_ff <= 32'(cfg_ff);
               ssfl_pkg::ADDR_STAT:
                  prdata_ff <= 32'(stat_byte);
               ssfl_pkg::ADDR_EVT:
                  prdata_ff <= 32'(evt_ff);
               ssfl_pkg::ADDR_MASK:
                  prdata_ff <= 32'(mask_ff);
               default:
                  prdata_ff <= '0;
            endcase
         end
         else if (acc)
            prdata_ff <= '0;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign sclk_out = sclk_out_ff;
   assign sclk_oe_n = sclk_oe_n_ff;
   assign mosi_out = mosi_out_ff;
   assign mosi_oe_n = mosi_oe_n_ff;
   assign miso_out = miso_out_ff;
   assign miso_oe_n = miso_oe_n_ff;
   assign ss_n_out = ss_n_out_ff;
   assign ss_oe_n = ss_oe_n_ff;

endmodule

// ==== inc/ssfl_pkg.sv ====
// constants and types shared by the serial status flag logic
// assumes a 10 MHz core clock and an APB register bus with 32-bit data
package ssfl_pkg;

   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int BUS_W = 32;
   localparam logic [7:0] IDX_TX = 8'h9A;
   localparam logic [7:0] IDX_RX = 8'h9B;
   localparam logic [7:0] IDX_CFG = 8'hE8;
   localparam logic [7:0] IDX_STAT = 8'hEA;
   localparam logic [7:0] IDX_EVT = 8'hEC;
   localparam logic [7:0] IDX_MASK = 8'hED;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_TX = 12'(IDX_TX) * ADDR_STEP;
   localparam logic [ADDR_W-1:0] ADDR_RX = 12'(IDX_RX) * ADDR_STEP;
   localparam logic [ADDR_W-1:0] ADDR_CFG = 12'(IDX_CFG) * ADDR_STEP;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 12'(IDX_STAT) * ADDR_STEP;
   localparam logic [ADDR_W-1:0] ADDR_EVT = 12'(IDX_EVT) * ADDR_STEP;
   localparam logic [ADDR_W-1:0] ADDR_MASK = 12'(IDX_MASK) * ADDR_STEP;

   // ----------------------------------------------------------------
   // serial_config_one fields
   // ----------------------------------------------------------------
   localparam int CFG_MODE = 0;
   localparam int CFG_LSB = 1;
   localparam int CFG_OVERWRITE = 2;
   localparam int CFG_SS_CHECK = 3;
   localparam int CFG_MASTER = 5;
   localparam logic [DATA_W-1:0] CFG_RESET = 8'h01;

   // ----------------------------------------------------------------
   // serial_flag_status fields
   // ----------------------------------------------------------------
   localparam int ST_TXBF = 0;
   localparam int ST_TXIRQ = 1;
   localparam int ST_TXUF = 2;
   localparam int ST_RXBF = 3;
   localparam int ST_RXIRQ = 4;
   localparam int ST_RXOF = 5;
   localparam int ST_MULTIMASTER_ERROR_FLAG = 6;
   localparam int ST_BUSY = 7;

   // ----------------------------------------------------------------
   // interrupt event bits
   // ----------------------------------------------------------------
   localparam int EV_W = 5;
   localparam int EV_RX = 0;
   localparam int EV_TX = 1;
   localparam int EV_OVF = 2;
   localparam int EV_MULTIMASTER_ERROR_FLAG = 3;
   localparam int EV_STOP = 4;
   localparam logic [EV_W-1:0] EV_RESET = 5'h00;

   // ----------------------------------------------------------------
   // timing and link
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_PERIOD_NS = 800;
   localparam int HALF_CYC_RAW = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
   localparam int BIT_CNT_W = 3;
   localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
   localparam int PIN_W = 4;
   // synchroniser order {ss_n, miso, mosi, sclk}; idle has ss_n high
   localparam logic [PIN_W-1:0] PIN_IDLE = 4'h8;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_SHIFT = 2'b10,
      ST_TAIL = 2'b11
   } ssfl_eng_e;

endpackage

// ==== design/ssfl_sync.sv ====
// two-stage synchroniser for pins arriving from outside the core clock
// assumes a synchronous active-high reset on the core clock
module ssfl_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   initial
   begin
      if (WIDTH < 1)
         $error("ssfl_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_ff <= RESET_VAL;
         sync_ff <= RESET_VAL;
      end
      else
      begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;

endmodule

// ==== sim/ssfl_core_props.sv ====
// checker for bus handshake and serial pin timing of the flag block
// assumes it is bound onto ssfl_core and sees only its ports
module ssfl_core_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic [ssfl_pkg::BUS_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sclk_out,
   input wire logic sclk_oe_n,
   input wire logic mosi_out,
   input wire logic mosi_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // --------------------------------
   // handshake and clock sequences
   // --------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_high;
      sclk_out [*3] ##1 !sclk_out;
   endsequence
   // --------------------------------
   // properties
   // --------------------------------
   a_ready_one_wait: assert property (s_wait |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready stuck");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   a_err_zero_data: assert property (pslverr |-> prdata == 32'h0)
      else $error("data on error");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper data bits set");
   a_sclk_half: assert property ($rose(sclk_out) |=> s_high)
      else $error("clock half period wrong");
   a_mosi_on_fall: assert property (!mosi_oe_n && $changed(mosi_out) |-> !sclk_out)
      else $error("data moved on rise");
   a_sclk_driven: assert property (sclk_out |-> !sclk_oe_n)
      else $error("clock high undriven");
endmodule

bind ssfl_core ssfl_core_props u_ssfl_core_props (.clk(clk), .reset(reset), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n));

// ==== sim/ssfl_slave_model.sv ====
// behavioural serial device on the far side of the port
// assumes mode zero clocking, byte frames framed by select low
module ssfl_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic ss_n,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sh = 8'h00;
   initial rx_byte = 8'h00;
   always @(negedge ss_n) sh = tx_byte;
   always @(posedge sclk) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
   always @(negedge sclk) if (!ss_n) sh = {sh[6:0], sh[7]};
   // released line shows the inverse of its last bit
   assign miso = ss_n ? ~sh[7] : sh[7];
endmodule

// ==== sim/ssfl_core_tb.sv ====
// self-checking bench for the serial flag block
// assumes the slave model on the serial side, bench as bus master
module ssfl_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [ssfl_pkg::ADDR_W-1:0] paddr = 12'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [ssfl_pkg::BUS_W-1:0] pwdata = 32'h0;
   logic [ssfl_pkg::BUS_W-1:0] prdata;
   logic pready, pslverr, irq, sclk_out, sclk_oe_n, mosi_out, mosi_oe_n;
   logic miso_out, miso_oe_n, ss_n_out, ss_oe_n, m_miso;
   logic tb_sclk = 1'h0;
   logic tb_mosi = 1'h0;
   logic tb_ss_n = 1'h1;
   logic [7:0] m_tx = 8'h00;
   logic [7:0] m_rx;
   int bad_count = 0;
   int checks = 0;
   wire sclk_w = sclk_oe_n ? tb_sclk : sclk_out;
   wire mosi_w = mosi_oe_n ? tb_mosi : mosi_out;
   wire miso_w = miso_oe_n ? m_miso : miso_out;
   wire ss_w = ss_oe_n ? tb_ss_n : ss_n_out;

   always #50 clk = ~clk;

   ssfl_core u_ssfl_core (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .sclk_in(sclk_w), .sclk_out(sclk_out),
      .sclk_oe_n(sclk_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
      .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_w),
      .ss_n_out(ss_n_out), .ss_oe_n(ss_oe_n));
   ssfl_slave_model u_ssfl_slave_model (.sclk(sclk_w), .mosi(mosi_w), .ss_n(ss_w),
      .tx_byte(m_tx), .miso(m_miso), .rx_byte(m_rx));

   // --------------------------------
   // shared tasks
   // --------------------------------
   task automatic stop_test();
      if (bad_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'h1 && n < 20);
      if (n == 20)
      begin
         bad_count++;
         stop_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      bus(1'h1, a, d, r, e);
   endtask

   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      bus(1'h0, a, 32'h0, r, e);
      chk(nm, r & m, exp);
   endtask

   task automatic idle();
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      r = 32'h80;
      while (r[7] !== 1'h0 && n < 100)
      begin
         bus(1'h0, ssfl_pkg::ADDR_STAT, 32'h0, r, e);
         n++;
      end
      if (n == 100)
      begin
         bad_count++;
         stop_test();
      end
   endtask

   task automatic frame(input logic [7:0] mb, input logic [7:0] txb);
      m_tx <= mb;
      wr(ssfl_pkg::ADDR_TX, {24'h0, txb});
      idle();
      chk("mosi byte", {24'h0, m_rx}, {24'h0, txb});
   endtask

   // --------------------------------
   // scenarios
   // --------------------------------
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rdc("config", ssfl_pkg::ADDR_CFG, 32'hFF, 32'h01);
      rdc("status", ssfl_pkg::ADDR_STAT, 32'hFF, 32'h00);
      bus(1'h0, 12'h004, 32'h0, r, e);
      chk("unmapped", {r[30:0], e}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h0);
   endtask

   task automatic t_master();
      wr(ssfl_pkg::ADDR_MASK, 32'h1F);
      wr(ssfl_pkg::ADDR_CFG, 32'h21);
      frame(8'hA5, 8'h3C);
      rdc("status", ssfl_pkg::ADDR_STAT, 32'hFF, 32'h1F);
      chk("irq", {31'h0, irq}, 32'h1);
      rdc("rx data", ssfl_pkg::ADDR_RX, 32'hFF, 32'hA5);
      rdc("status", ssfl_pkg::ADDR_STAT, 32'hFF, 32'h07);
      wr(ssfl_pkg::ADDR_CFG, 32'h01);
      wr(ssfl_pkg::ADDR_TX, 32'h77);
      rdc("status", ssfl_pkg::ADDR_STAT, 32'hFF, 32'h05);
      wr(ssfl_pkg::ADDR_STAT, 32'h00);
      rdc("status", ssfl_pkg::ADDR_STAT, 32'hFF, 32'h01);
      wr(ssfl_pkg::ADDR_MASK, 32'h00);
      @(posedge clk);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(ssfl_pkg::ADDR_MASK, 32'h1F);
      @(posedge clk);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(ssfl_pkg::ADDR_EVT, 32'h1F);
      @(posedge clk);
      chk("irq", {31'h0, irq}, 32'h0);
   endtask

   task automatic t_slave();
      logic [7:0] b;
      b = 8'hC3;
      wr(ssfl_pkg::ADDR_CFG, 32'h00);
      wr(ssfl_pkg::ADDR_EVT, 32'h1F);
      tb_ss_n <= 1'h0;
      repeat (8) @(posedge clk);
      for (int i = 7; i >= 0; i--)
      begin
         tb_mosi <= b[i];
         repeat (4) @(posedge clk);
         tb_sclk <= 1'h1;
         repeat (4) @(posedge clk);
         tb_sclk <= 1'h0;
      end
      repeat (8) @(posedge clk);
      tb_ss_n <= 1'h1;
      tb_mosi <= ~b[0];
      rdc("status", ssfl_pkg::ADDR_STAT, 32'h38, 32'h18);
      chk("irq", {31'h0, irq}, 32'h1);
      rdc("rx data", ssfl_pkg::ADDR_RX, 32'hFF, 32'hC3);
      wr(ssfl_pkg::ADDR_EVT, 32'h1F);
   endtask

   task automatic t_over();
      for (int ow = 0; ow < 2; ow++)
      begin
         wr(ssfl_pkg::ADDR_CFG, ow ? 32'h25 : 32'h21);
         frame(8'h5A, 8'h01);
         frame(8'hC6, 8'h02);
         rdc("overflow", ssfl_pkg::ADDR_STAT, 32'h20, 32'h20);
         rdc("rx data", ssfl_pkg::ADDR_RX, 32'hFF, ow ? 32'hC6 : 32'h5A);
         rdc("status", ssfl_pkg::ADDR_STAT, 32'h38, 32'h00);
      end
   endtask

   task automatic t_multimaster_error_flag();
      wr(ssfl_pkg::ADDR_CFG, 32'h29);
      wr(ssfl_pkg::ADDR_EVT, 32'h1F);
      wr(ssfl_pkg::ADDR_MASK, 32'h08);
      wr(ssfl_pkg::ADDR_TX, 32'h0F);
      tb_ss_n <= 1'h0;
      idle();
      tb_ss_n <= 1'h1;
      rdc("mm error", ssfl_pkg::ADDR_STAT, 32'h40, 32'h40);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(ssfl_pkg::ADDR_STAT, 32'hFF);
      rdc("mm error", ssfl_pkg::ADDR_STAT, 32'h40, 32'h40);
      wr(ssfl_pkg::ADDR_STAT, 32'hBF);
      rdc("mm error", ssfl_pkg::ADDR_STAT, 32'h40, 32'h00);
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      t_reset();
      t_master();
      t_slave();
      t_over();
      t_multimaster_error_flag();
      stop_test();
   end
endmodule
